/* File: include/gpbpt_map.svh */
/*
  register addresses, field positions, reset values and pad slots for the
  pin buffer and pass-through block.
  assumes: included by bare name from the package and the design files.
*/
`ifndef GPBPT_MAP_SVH
`define GPBPT_MAP_SVH

// register addresses
`define GPBPT_SFR_DATA_ADDR 8'h80
`define GPBPT_PTSEL_ADDR    16'h7f85
`define GPBPT_HBUF_ADDR     16'h7faa
`define GPBPT_SBUF_ADDR     16'h7fac
`define GPBPT_SFR_DIR_ADDR  16'h7fad

// reset values and field layout
`define GPBPT_RST_NIB       4'h0
`define GPBPT_RST_PAIR      2'h0
`define GPBPT_RSVD_HI4      4'h0
`define GPBPT_RSVD_HI6      6'h00
`define GPBPT_RD_IDLE       8'h00
`define GPBPT_BIT_UNMAPPED  1'b0
`define GPBPT_GOZ_BIT       0
`define GPBPT_GIS_BIT       1

// pad slots inside the ten-pad driver
`define GPBPT_PAD_N         10
`define GPBPT_TGT_LO        0
`define GPBPT_GOZ_SLOT      4
`define GPBPT_GIS_SLOT      5
`define GPBPT_SFR_LO        6

`endif

/* File: include/gpbpt_pkg.sv */
/*
  types and shared functions of the pin buffer and pass-through block.
  assumes: gpbpt_map.svh is on the include path.
*/
`default_nettype none
`include "gpbpt_map.svh"

package gpbpt_pkg;

  typedef logic [3:0] gpbpt_nib_t;

  // register selected by a memory-mapped address
  typedef enum logic [2:0] {
    GPBPT_SEL_NONE    = 3'b000,
    GPBPT_SEL_PTSEL   = 3'b001,
    GPBPT_SEL_HBUF    = 3'b010,
    GPBPT_SEL_SBUF    = 3'b011,
    GPBPT_SEL_SFR_DIR = 3'b100
  } gpbpt_sel_t;

  // decode of the memory-mapped address, shared by reads and writes
  function automatic gpbpt_sel_t gpbpt_decode(input logic [15:0] addr);
    gpbpt_sel_t s;
    s = GPBPT_SEL_NONE;
    if (addr == `GPBPT_PTSEL_ADDR) s = GPBPT_SEL_PTSEL;
    if (addr == `GPBPT_HBUF_ADDR) s = GPBPT_SEL_HBUF;
    if (addr == `GPBPT_SBUF_ADDR) s = GPBPT_SEL_SBUF;
    if (addr == `GPBPT_SFR_DIR_ADDR) s = GPBPT_SEL_SFR_DIR;
    return s;
  endfunction : gpbpt_decode

  // pad drive: returns {oe, out}; open-drain only ever pulls low
  function automatic logic [1:0] gpbpt_drive(input logic od,
                                             input logic en,
                                             input logic val);
    logic [1:0] r;
    r = od ? {en & ~val, 1'b0} : {en, val};
    return r;
  endfunction : gpbpt_drive

endpackage : gpbpt_pkg

`default_nettype wire

/* File: include/gpbpt_pad_if.sv */
/*
  carrier between the register logic and the pad driver.
  assumes: one clock domain; the pad side only reads these signals.
*/
`default_nettype none
`include "gpbpt_map.svh"

interface gpbpt_pad_if;
  logic [`GPBPT_PAD_N-1:0] drv_en;      // wants to drive the pad
  logic [`GPBPT_PAD_N-1:0] drv_val;     // level to present
  logic [`GPBPT_PAD_N-1:0] open_drain;  // 1 = open-drain buffer

  modport ctl (output drv_en, output drv_val, output open_drain);
  modport pad (input drv_en, input drv_val, input open_drain);
endinterface : gpbpt_pad_if

`default_nettype wire

/* File: rtl/gpbpt_pad.sv */
/*
  registered pad driver for the ten driven pins of the block.
  assumes: controls arrive on gpbpt_pad_if from the register logic; the
  board resolves the wire from out and oe and provides pull-ups.
*/
`default_nettype none
`include "gpbpt_map.svh"

module gpbpt_pad
  import gpbpt_pkg::*;
(
  input  wire logic                    clk,     // system clock
  input  wire logic                    resetn,  // sync reset, active low
  input  wire logic                    ce,      // clock enable
  gpbpt_pad_if.pad                     ctl,     // drive controls
  output var  logic [`GPBPT_PAD_N-1:0] pin_out, // pad output level
  output var  logic [`GPBPT_PAD_N-1:0] pin_oe   // pad output enable
);

  logic [`GPBPT_PAD_N-1:0] out_next;
  logic [`GPBPT_PAD_N-1:0] oe_next;

  // buffer type applied per pad; registering keeps the pins glitch free
  always_comb begin
    out_next = '0;
    oe_next  = '0;
    for (int i = 0; i < `GPBPT_PAD_N; i++) begin
      {oe_next[i], out_next[i]} = gpbpt_drive(ctl.open_drain[i],
                                              ctl.drv_en[i],
                                              ctl.drv_val[i]);
    end
  end

  // all pads released while in reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (ce) begin
      pin_out <= out_next;
      pin_oe  <= oe_next;
    end
  end

endmodule : gpbpt_pad

`default_nettype wire

/* File: rtl/gpbpt_top.sv */
/*
  pin buffer-type, bit-addressable pin port and pass-through logic.
  assumes: the controller drives the memory-mapped, byte-wide special
  register and bit ports synchronously to clk; the ordinary group-h
  output and direction values come from the general pin logic outside.
*/
`default_nettype none
`include "gpbpt_map.svh"

// Function
// - a group-h pad is open-drain when its buffer bit is one, else push-pull.
// - group-h buffer register holds four bits, upper bits read zero, reset 0.
// - standalone buffer register: bit 0 output pin, bit 1 io pin seven.
// - the pin data register is bit addressable at base plus bit index.
// - pin data register has four read/write bits, upper zero, reset 0.
// - pin direction register, one means output, resets to all inputs.
// - four pass-through ports pair source pin k with target pin k.
// - with a select bit at zero both pins of the pair act normally.
// - with a select bit at one the target pin shows the source level.
// - in pass-through the target is always an output.
// - in normal mode the target direction follows its direction bit.
// - select register is written by the controller only, reset 0.
// - source pin levels are offered to interrupt and wake logic.
module gpbpt_top
  import gpbpt_pkg::*;
(
  input  wire logic        clk,            // system clock, 50 mhz
  input  wire logic        resetn,         // sync reset, active low
  input  wire logic        ce,             // clock enable, freezes all
  input  wire logic [15:0] mmcr_addr,      // memory-mapped address
  input  wire logic        mmcr_wr,        // memory-mapped write strobe
  input  wire logic        mmcr_rd,        // memory-mapped read strobe
  input  wire logic [7:0]  mmcr_wdata,     // memory-mapped write data
  output var  logic [7:0]  mmcr_rdata,     // memory-mapped read data
  input  wire logic [7:0]  sfr_addr,       // special register address
  input  wire logic        sfr_wr,         // special register write
  input  wire logic        sfr_rd,         // special register read
  input  wire logic [7:0]  sfr_wdata,      // special register wdata
  output var  logic [7:0]  sfr_rdata,      // special register rdata
  input  wire logic [7:0]  bit_addr,       // bit address
  input  wire logic        bit_wr,         // set or clear one bit
  input  wire logic        bit_val,        // 1 = set, 0 = clear
  input  wire logic        bit_rd,         // read one bit
  output var  logic        bit_rdata,      // bit read result
  input  wire logic [3:0]  gpio_h_out,     // normal target out values
  input  wire logic [3:0]  gpio_h_dir,     // normal target directions
  input  wire logic [3:0]  src_pin_in,     // source pin levels
  output var  logic [3:0]  src_level,      // source levels to irq logic
  output var  logic [3:0]  src_change,     // source level change pulse
  output var  logic [3:0]  tgt_pin_out,    // target pin output level
  output var  logic [3:0]  tgt_pin_oe,     // target pin output enable
  input  wire logic        goz_val,        // general output zero value
  output var  logic        goz_pin_out,    // general output zero level
  output var  logic        goz_pin_oe,     // general output zero enable
  input  wire logic        gis_val,        // general io seven value
  input  wire logic        gis_dir,        // general io seven, 1 = out
  output var  logic        gis_pin_out,    // general io seven level
  output var  logic        gis_pin_oe,     // general io seven enable
  input  wire logic [3:0]  sfr_pin_in,     // bit port pin levels
  output var  logic [3:0]  sfr_pin_out,    // bit port output level
  output var  logic [3:0]  sfr_pin_oe      // bit port output enable
);

  // register state
  gpbpt_nib_t pass_through_select_reg;
  gpbpt_nib_t pass_through_select_next;
  gpbpt_nib_t hbuf_reg;
  gpbpt_nib_t hbuf_next;
  logic [1:0] sbuf_reg;
  logic [1:0] sbuf_next;
  gpbpt_nib_t sfr_data_reg;
  gpbpt_nib_t sfr_data_next;
  gpbpt_nib_t sfr_dir_reg;
  gpbpt_nib_t sfr_dir_next;
  logic [3:0] src_level_reg;

  // decoded accesses
  gpbpt_sel_t mm_sel;
  logic       mm_we;
  logic       sfr_hit;
  logic       bit_hit;
  logic [1:0] bit_idx;
  logic [3:0] bit_mask;
  gpbpt_nib_t sfr_view;
  logic [7:0] mm_rd_val;
  logic [3:0] pt_en;
  logic [3:0] wdata_lo;

  gpbpt_pad_if pad_bus ();
  logic [`GPBPT_PAD_N-1:0] pin_out;
  logic [`GPBPT_PAD_N-1:0] pin_oe;

  // address decode; the bit window covers the data register's four bits
  assign mm_sel   = gpbpt_decode(mmcr_addr);
  assign mm_we    = ce & mmcr_wr;
  assign sfr_hit  = (sfr_addr == `GPBPT_SFR_DATA_ADDR);
  assign bit_hit  = (bit_addr[7:2] == 6'(`GPBPT_SFR_DATA_ADDR >> 2));
  assign bit_idx  = bit_addr[1:0];
  assign bit_mask = 4'h1 << bit_idx;
  assign wdata_lo = mmcr_wdata[3:0];

  // select register: only the controller bus reaches it
  assign pass_through_select_next =
    (mm_we && mm_sel == GPBPT_SEL_PTSEL) ? mmcr_wdata[3:0]
                                         : pass_through_select_reg;

  // buffer type and direction registers keep only their documented bits
  assign hbuf_next = (mm_we && mm_sel == GPBPT_SEL_HBUF)
                     ? mmcr_wdata[3:0] : hbuf_reg;
  assign sbuf_next = (mm_we && mm_sel == GPBPT_SEL_SBUF)
                     ? mmcr_wdata[1:0] : sbuf_reg;
  assign sfr_dir_next = (mm_we && mm_sel == GPBPT_SEL_SFR_DIR)
                        ? mmcr_wdata[3:0] : sfr_dir_reg;

  // bit port data: byte write first, a bit write in the same cycle wins
  // since it is the later, narrower intent; bits 4..7 are not stored
  always_comb begin
    sfr_data_next = sfr_data_reg;
    if (ce && sfr_wr && sfr_hit) begin
      sfr_data_next = sfr_wdata[3:0];
    end
    if (ce && bit_wr && bit_hit && !bit_addr[2]) begin
      sfr_data_next = bit_val ? (sfr_data_next | bit_mask)
                              : (sfr_data_next & ~bit_mask);
    end
  end

  // register update; every control bit clears at reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pass_through_select_reg <= `GPBPT_RST_NIB;
      hbuf_reg     <= `GPBPT_RST_NIB;
      sbuf_reg     <= `GPBPT_RST_PAIR;
      sfr_data_reg <= `GPBPT_RST_NIB;
      sfr_dir_reg  <= `GPBPT_RST_NIB;
    end else begin
      pass_through_select_reg <= pass_through_select_next;
      hbuf_reg     <= hbuf_next;
      sbuf_reg     <= sbuf_next;
      sfr_data_reg <= sfr_data_next;
      sfr_dir_reg  <= sfr_dir_next;
    end
  end

  // inputs read back their live level, outputs their stored bit
  assign sfr_view = (sfr_dir_reg & sfr_data_reg)
                  | (~sfr_dir_reg & sfr_pin_in);

  // memory-mapped read mux; unmapped addresses read zero
  assign mm_rd_val =
    (mm_sel == GPBPT_SEL_PTSEL)   ? {`GPBPT_RSVD_HI4,
                                     pass_through_select_reg} :
    (mm_sel == GPBPT_SEL_HBUF)    ? {`GPBPT_RSVD_HI4, hbuf_reg} :
    (mm_sel == GPBPT_SEL_SBUF)    ? {`GPBPT_RSVD_HI6, sbuf_reg} :
    (mm_sel == GPBPT_SEL_SFR_DIR) ? {`GPBPT_RSVD_HI4, sfr_dir_reg}
                                  : `GPBPT_RD_IDLE;

  // read data are registered and hold until the next read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mmcr_rdata <= `GPBPT_RD_IDLE;
      sfr_rdata  <= `GPBPT_RD_IDLE;
      bit_rdata  <= `GPBPT_BIT_UNMAPPED;
    end else if (ce) begin
      if (mmcr_rd) mmcr_rdata <= mm_rd_val;
      if (sfr_rd) sfr_rdata <= sfr_hit ? {`GPBPT_RSVD_HI4, sfr_view}
                                       : `GPBPT_RD_IDLE;
      if (bit_rd) bit_rdata <= (bit_hit && !bit_addr[2])
                               ? sfr_view[bit_idx]
                               : `GPBPT_BIT_UNMAPPED;
    end
  end

  // source levels for the interrupt and wake logic, with a change pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_level_reg <= `GPBPT_RST_NIB;
      src_change    <= `GPBPT_RST_NIB;
    end else if (ce) begin
      src_level_reg <= src_pin_in;
      src_change    <= src_pin_in ^ src_level_reg;
    end
  end
  assign src_level = src_level_reg;

  // pass-through mux: pair k is source k onto target k
  assign pt_en = pass_through_select_reg;

  // target pads: pass-through overrides the normal output path
  assign pad_bus.drv_val[3:0] = (pt_en & src_pin_in)
                              | (~pt_en & gpio_h_out);
  assign pad_bus.drv_en[3:0]  = pt_en | gpio_h_dir;
  assign pad_bus.open_drain[3:0] = hbuf_reg;

  // standalone pads; the general output zero pin always has drv_en set
  assign pad_bus.drv_val[`GPBPT_GOZ_SLOT]    = goz_val;
  assign pad_bus.drv_en[`GPBPT_GOZ_SLOT]     = 1'b1;
  assign pad_bus.open_drain[`GPBPT_GOZ_SLOT] =
    sbuf_reg[`GPBPT_GOZ_BIT];
  assign pad_bus.drv_val[`GPBPT_GIS_SLOT]    = gis_val;
  assign pad_bus.drv_en[`GPBPT_GIS_SLOT]     = gis_dir;
  assign pad_bus.open_drain[`GPBPT_GIS_SLOT] =
    sbuf_reg[`GPBPT_GIS_BIT];

  // bit port pads are push-pull, steered by the direction register
  assign pad_bus.drv_val[9:6]    = sfr_data_reg;
  assign pad_bus.drv_en[9:6]     = sfr_dir_reg;
  assign pad_bus.open_drain[9:6] = 4'h0;

  gpbpt_pad u_pad (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .ctl     (pad_bus.pad),
    .pin_out (pin_out),
    .pin_oe  (pin_oe)
  );

  // pad outputs are the driver's flip-flops
  assign tgt_pin_out = pin_out[3:0];
  assign tgt_pin_oe  = pin_oe[3:0];
  assign goz_pin_out = pin_out[`GPBPT_GOZ_SLOT];
  assign goz_pin_oe  = pin_oe[`GPBPT_GOZ_SLOT];
  assign gis_pin_out = pin_out[`GPBPT_GIS_SLOT];
  assign gis_pin_oe  = pin_oe[`GPBPT_GIS_SLOT];
  assign sfr_pin_out = pin_out[9:6];
  assign sfr_pin_oe  = pin_oe[9:6];

  // checks; pads lag their controls by one enabled edge
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_hpad_open_drain: assert property (
    ce && hbuf_reg[0] && (pt_en[0] || gpio_h_dir[0])
    |=> !tgt_pin_out[0] && (tgt_pin_oe[0] == !$past(pad_bus.drv_val[0])))
    else $error("open-drain target pad drove high");

  a_hbuf_readback: assert property (
    (mm_we && mm_sel == GPBPT_SEL_HBUF)
    ##1 (ce && mmcr_rd && !mmcr_wr && mm_sel == GPBPT_SEL_HBUF)
    |=> mmcr_rdata == {4'h0, $past(wdata_lo, 2)})
    else $error("group h buffer readback wrong");

  a_sbuf_pushpull: assert property (
    (mm_we && mm_sel == GPBPT_SEL_SBUF && !mmcr_wdata[0])
    ##1 ce |=> goz_pin_oe && goz_pin_out == $past(goz_val))
    else $error("output zero pad not push-pull");

  a_bit_set_clr: assert property (
    ce && bit_wr && bit_hit && !bit_addr[2] && !(sfr_wr && sfr_hit)
    |=> sfr_data_reg[$past(bit_idx)] == $past(bit_val))
     else $error("bit instruction missed its pin bit");

  a_sfr_rsvd_zero: assert property (
    sfr_rdata[7:4] == 4'h0 && mmcr_rdata[7:4] == 4'h0)
    else $error("reserved read bits not zero");

  a_sfr_dir_input: assert property (
    ce && !sfr_dir_reg[1] |=> !sfr_pin_oe[1])
    else $error("input bit port pin is driven");

  a_pass_follow: assert property (
    ce && pt_en[2] && !hbuf_reg[2]
    |=> tgt_pin_oe[2] && (tgt_pin_out[2] == $past(src_pin_in[2])))
    else $error("pass-through target not following source");

  a_normal_dir: assert property (
    ce && !pt_en[3] && !hbuf_reg[3]
    |=> tgt_pin_oe[3] == $past(gpio_h_dir[3])
        && tgt_pin_out[3] == $past(gpio_h_out[3]))
    else $error("normal target pad not following gpio path");

  a_sel_reset: assert property (
    $rose(resetn) |-> pass_through_select_reg == 4'h0
                      && hbuf_reg == 4'h0 && sfr_dir_reg == 4'h0)
    else $error("control registers not cleared by reset");

  a_src_change: assert property (
    ce ##1 ce && (src_pin_in[0] != src_level_reg[0])
    |=> src_change[0] && src_level[0] == $past(src_pin_in[0]))
    else $error("source level change not reported");

  a_sfr_readback: assert property (
    ce && sfr_rd && sfr_hit && sfr_dir_reg[0]
    |=> sfr_rdata[0] == $past(sfr_data_reg[0]))
    else $error("output pin read did not return data bit");

endmodule : gpbpt_top

`default_nettype wire

/* File: dv/gpbpt_board.sv */
/*
  board-side model of the pins: pull-ups on the target pins and an
  external driver on the bit port pins whenever the block releases them.
  assumes: the bench supplies the external bit port levels.
*/
`default_nettype none

module gpbpt_board (
  input  wire logic [3:0] tgt_out,  // target pad level
  input  wire logic [3:0] tgt_oe,   // target pad enable
  input  wire logic [3:0] sfr_out,  // bit port pad level
  input  wire logic [3:0] sfr_oe,   // bit port pad enable
  input  wire logic [3:0] sfr_ext,  // level the board drives
  output var  logic [3:0] tgt_wire, // resolved target wire
  output var  logic [3:0] sfr_wire  // resolved bit port wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // a released target floats high on its pull-up, so open-drain works
  assign tgt_wire = (tgt_oe & tgt_out) | ~tgt_oe;
  // the board only drives a bit port pin the block has let go of
  assign sfr_wire = (sfr_oe & sfr_out) | (~sfr_oe & sfr_ext);
endmodule : gpbpt_board

`default_nettype wire

/* File: dv/gpio_buffer_and_passthrough_cfg_tb.sv */
/*
  self-checking bench for the pin buffer and pass-through block.
  assumes: gpbpt_map.svh on the include path; board model compiled first.
*/
`default_nettype none
`include "gpbpt_map.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, exp, got); end end

module gpio_buffer_and_passthrough_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, resetn, ce, mmcr_wr, mmcr_rd, sfr_wr, sfr_rd;
  logic        bit_wr, bit_val, bit_rd, goz_val, gis_val, gis_dir;
  logic [15:0] mmcr_addr;
  logic [7:0]  mmcr_wdata, sfr_addr, sfr_wdata, bit_addr, rd;
  logic [7:0]  mmcr_rdata, sfr_rdata;
  logic [3:0]  gpio_h_out, gpio_h_dir, src_pin_in, sfr_ext, src_level;
  logic [3:0]  src_change, tgt_pin_out, tgt_pin_oe, sfr_pin_out;
  logic [3:0]  sfr_pin_oe, sfr_pin_in, tgt_wire;
  logic        bit_rdata, goz_pin_out, goz_pin_oe, gis_pin_out, gis_pin_oe;
  logic        b;
  int          mismatches, n_tests;

  gpbpt_top u_gpbpt_top (.clk(clk), .resetn(resetn), .ce(ce),
    .mmcr_addr(mmcr_addr), .mmcr_wr(mmcr_wr), .mmcr_rd(mmcr_rd),
    .mmcr_wdata(mmcr_wdata), .mmcr_rdata(mmcr_rdata), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_val(bit_val), .bit_rd(bit_rd), .bit_rdata(bit_rdata),
    .gpio_h_out(gpio_h_out), .gpio_h_dir(gpio_h_dir),
    .src_pin_in(src_pin_in), .src_level(src_level),
    .src_change(src_change), .tgt_pin_out(tgt_pin_out),
    .tgt_pin_oe(tgt_pin_oe), .goz_val(goz_val), .goz_pin_out(goz_pin_out),
    .goz_pin_oe(goz_pin_oe), .gis_val(gis_val), .gis_dir(gis_dir),
    .gis_pin_out(gis_pin_out), .gis_pin_oe(gis_pin_oe),
    .sfr_pin_in(sfr_pin_in), .sfr_pin_out(sfr_pin_out),
    .sfr_pin_oe(sfr_pin_oe));

  gpbpt_board u_gpbpt_board (.tgt_out(tgt_pin_out), .tgt_oe(tgt_pin_oe),
    .sfr_out(sfr_pin_out), .sfr_oe(sfr_pin_oe), .sfr_ext(sfr_ext),
    .tgt_wire(tgt_wire), .sfr_wire(sfr_pin_in));

  // 50 mhz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // bus cycles: strobe up for exactly one rising edge
  task automatic mm_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    mmcr_addr = a;
    mmcr_wdata = d;
    mmcr_wr = 1'b1;
    @(negedge clk);
    mmcr_wr = 1'b0;
  endtask : mm_wr

  task automatic mm_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    mmcr_addr = a;
    mmcr_rd = 1'b1;
    @(negedge clk);
    mmcr_rd = 1'b0;
    d = mmcr_rdata;
  endtask : mm_rd

  // write then read in the very next cycle, the tightest legal order
  task automatic mm_wrd(input logic [15:0] a, input logic [7:0] w,
                        output logic [7:0] d);
    @(negedge clk);
    mmcr_addr = a;
    mmcr_wdata = w;
    mmcr_wr = 1'b1;
    @(negedge clk);
    mmcr_wr = 1'b0;
    mmcr_rd = 1'b1;
    @(negedge clk);
    mmcr_rd = 1'b0;
    d = mmcr_rdata;
  endtask : mm_wrd

  task automatic sfr_wb(input logic [7:0] d);
    @(negedge clk);
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : sfr_wb

  task automatic sfr_rb(output logic [7:0] d);
    @(negedge clk);
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : sfr_rb

  task automatic bit_op(input logic [7:0] a, input logic v, input logic r);
    @(negedge clk);
    bit_addr = a;
    bit_val = v;
    bit_wr = ~r;
    bit_rd = r;
    @(negedge clk);
    bit_wr = 1'b0;
    bit_rd = 1'b0;
    b = bit_rdata;
  endtask : bit_op

  // pads trail a register write by two edges; inputs get one extra
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic t_reset_vals;
    logic [15:0] al[4];
    al = '{`GPBPT_PTSEL_ADDR, `GPBPT_HBUF_ADDR, `GPBPT_SBUF_ADDR,
           `GPBPT_SFR_DIR_ADDR};
    foreach (al[i]) begin
      mm_rd(al[i], rd);
      `CHK("reset value", 8'h00, rd)
    end
    sfr_rb(rd);
    `CHK("pin data reset", 8'h00, rd)
  endtask : t_reset_vals

  // every writable bit sticks, reserved bits read zero, ce gates writes
  task automatic t_regs;
    logic [15:0] al[4];
    logic [7:0]  mk[4];
    al = '{`GPBPT_PTSEL_ADDR, `GPBPT_HBUF_ADDR, `GPBPT_SBUF_ADDR,
           `GPBPT_SFR_DIR_ADDR};
    mk = '{8'h0f, 8'h0f, 8'h03, 8'h0f};
    foreach (al[i]) begin
      mm_wrd(al[i], 8'hff, rd);
      `CHK("writable mask", mk[i], rd)
    end
    ce = 1'b0;
    mm_wr(`GPBPT_HBUF_ADDR, 8'h0a);
    ce = 1'b1;
    mm_rd(`GPBPT_HBUF_ADDR, rd);
    `CHK("frozen write", 8'h0f, rd)
    mm_wr(16'h7fab, 8'hff);
    mm_rd(16'h7fab, rd);
    `CHK("unmapped read", 8'h00, rd)
    // a mid-run reset must clear every control bit again
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    foreach (al[i]) begin
      mm_rd(al[i], rd);
      `CHK("mid reset value", 8'h00, rd)
    end
  endtask : t_regs

  // low two targets open-drain, high two push-pull
  task automatic t_hbuf;
    gpio_h_dir = 4'hf;
    gpio_h_out = 4'b0101;
    mm_wr(`GPBPT_HBUF_ADDR, 8'h03);
    settle();
    `CHK("group h oe", 4'b1110, tgt_pin_oe)
    `CHK("group h out", 4'b0100, tgt_pin_out)
    `CHK("group h wire", 4'b0101, tgt_wire)
    gpio_h_dir = 4'b0011;
    settle();
    `CHK("group h dir", 4'b0010, tgt_pin_oe)
  endtask : t_hbuf

  // each select bit must steer only its own pair, target forced output
  task automatic t_pass;
    gpio_h_dir = 4'h0;
    gpio_h_out = 4'hf;
    src_pin_in = 4'b1010;
    mm_wr(`GPBPT_HBUF_ADDR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      mm_wr(`GPBPT_PTSEL_ADDR, 8'(1 << k));
      settle();
      `CHK("pass oe", 4'(1 << k), tgt_pin_oe)
      `CHK("pass level", src_pin_in[k], tgt_pin_out[k])
    end
    mm_wr(`GPBPT_PTSEL_ADDR, 8'h0f);
    mm_wr(`GPBPT_HBUF_ADDR, 8'h03);
    src_pin_in = 4'b0101;
    @(negedge clk);
    `CHK("source change", 4'hf, src_change)
    settle();
    `CHK("source change end", 4'h0, src_change)
    `CHK("pass wire", 4'b0101, tgt_wire)
    `CHK("source level", 4'b0101, src_level)
    mm_wr(`GPBPT_PTSEL_ADDR, 8'h00);
    settle();
    `CHK("pass off", 4'h0, tgt_pin_oe)
  endtask : t_pass

  task automatic t_sbuf;
    goz_val = 1'b1;
    gis_val = 1'b1;
    gis_dir = 1'b1;
    mm_wr(`GPBPT_SBUF_ADDR, 8'h03);
    settle();
    `CHK("goz od high", 1'b0, goz_pin_oe)
    `CHK("gis od high", 1'b0, gis_pin_oe)
    mm_wr(`GPBPT_SBUF_ADDR, 8'h00);
    settle();
    `CHK("goz push", 2'b11, {goz_pin_oe, goz_pin_out})
    `CHK("gis push", 2'b11, {gis_pin_oe, gis_pin_out})
  endtask : t_sbuf

  // mixed directions: outputs read their data, inputs the board level
  task automatic t_sfr;
    mm_wr(`GPBPT_SFR_DIR_ADDR, 8'h05);
    sfr_ext = 4'b1010;
    sfr_wb(8'hf3);
    settle();
    `CHK("bit port oe", 4'h5, sfr_pin_oe)
    `CHK("bit port out", 4'h1, sfr_pin_out & 4'h5)
    sfr_rb(rd);
    `CHK("bit port read", 8'h0b, rd)
  endtask : t_sfr

  task automatic t_bits;
    mm_wr(`GPBPT_SFR_DIR_ADDR, 8'h0f);
    sfr_wb(8'h00);
    bit_op(8'h82, 1'b1, 1'b0);
    bit_op(8'h80, 1'b1, 1'b0);
    bit_op(8'h80, 1'b0, 1'b0);
    bit_op(8'h86, 1'b1, 1'b0);
    sfr_rb(rd);
    `CHK("bit set clear", 8'h04, rd)
    bit_op(8'h82, 1'b0, 1'b1);
    `CHK("bit read", 1'b1, b)
    bit_op(8'h85, 1'b0, 1'b1);
    `CHK("bit read high", 1'b0, b)
    settle();
    `CHK("bit pad", 4'h4, sfr_pin_out)
  endtask : t_bits

  // a hung handshake must not stall the run
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    {resetn, mmcr_wr, mmcr_rd, sfr_wr, sfr_rd, bit_wr, bit_rd} = '0;
    {bit_val, goz_val, gis_val, gis_dir} = '0;
    ce = 1'b1;
    mmcr_addr = 16'h0000;
    {mmcr_wdata, sfr_wdata, bit_addr} = '0;
    sfr_addr = 8'h80;
    {gpio_h_out, gpio_h_dir, src_pin_in, sfr_ext} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_reset_vals();
    t_regs();
    t_hbuf();
    t_pass();
    t_sbuf();
    t_sfr();
    t_bits();
    wrap_up();
  end
endmodule : gpio_buffer_and_passthrough_cfg_tb

`default_nettype wire
